// File: shared/pief_pkg.sv
// Package with register offsets, field positions and reset values of the interrupt bank.
package pief_pkg;
   // ----------------------------------------------------------------
   // Register byte offsets on the Avalon-MM slave.
   // ----------------------------------------------------------------
   localparam logic [4:0] OFS_ENABLE_TWO = 5'h00;
   localparam logic [4:0] OFS_REQUEST_ONE = 5'h04;
   localparam logic [4:0] OFS_CORE_CTRL = 5'h08;
   localparam logic [4:0] OFS_IRQ_STATUS = 5'h0c;
   localparam logic [4:0] OFS_IRQ_MASK = 5'h10;

   // ----------------------------------------------------------------
   // Field positions.
   // ----------------------------------------------------------------
   // Enable-two: bit 7 unimplemented, bits 6..0 writable.
   localparam logic [7:0] ENABLE_TWO_MASK = 8'h7f;
   localparam int NUM_OSC_IRQ_ENABLE_BIT = 6;
   localparam int COMP_OUT_SHUTDOWN_IRQ_ENABLE_BIT = 5;
   localparam int ZERO_CROSS_IRQ_ENABLE_BIT = 4;
   // Request-one: bits 5 and 4 are read-only and follow their source.
   localparam logic [7:0] REQUEST_ONE_RW_MASK = 8'hcf;
   localparam int TIMER_ONE_GATE_FLAG_BIT = 7;
   localparam int TIMER_ONE_OVERFLOW_FLAG_BIT = 0;
   // Core control register gate bits.
   localparam int GLOBAL_IRQ_GATE_BIT = 7;
   localparam int PERIPHERAL_IRQ_GATE_BIT = 6;

   // ----------------------------------------------------------------
   // Reset values.
   // ----------------------------------------------------------------
   localparam logic [7:0] ENABLE_TWO_RST = 8'h00;
   localparam logic [7:0] REQUEST_ONE_RST = 8'h00;
   localparam logic [7:0] CORE_CTRL_RST = 8'h00;
   localparam logic [7:0] IRQ_STATUS_RST = 8'h00;
   localparam logic [7:0] IRQ_MASK_RST = 8'h00;
endpackage : pief_pkg

// File: hw/pief_evsync.sv
// Three-stage synchroniser bank with agreement filter and rising-edge pulse.
`timescale 1ns/10ps
module pief_evsync (
   // Clock and reset.
   input wire logic clk,
   input wire logic resetn,
   // Asynchronous source lines.
   input wire logic [7:0] src_async,
   // Filtered level and one-cycle rise pulse, both registered.
   output logic [7:0] level_q,
   output logic [7:0] rise_q
);
   // Synchroniser stages; stage one feeds only stage two.
   logic [7:0] s1_q;
   logic [7:0] s2_q;
   logic [7:0] s3_q;

   genvar i;
   // A bit counts as changed once stages two and three agree on the new value.
   generate
      for (i = 0; i < 8; i++) begin : g_bit
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               s1_q[i] <= 1'b0;
               s2_q[i] <= 1'b0;
               s3_q[i] <= 1'b0;
               level_q[i] <= 1'b0;
               rise_q[i] <= 1'b0;
            end else begin
               s1_q[i] <= src_async[i];
               s2_q[i] <= s1_q[i];
               s3_q[i] <= s2_q[i];
               // Only a settled, agreed value is passed on.
               if (s2_q[i] == s3_q[i]) begin
                  level_q[i] <= s3_q[i];
                  rise_q[i] <= s3_q[i] & ~level_q[i];
               end else begin
                  rise_q[i] <= 1'b0;
               end
            end
         end
      end
   endgenerate
endmodule : pief_evsync

// File: hw/pief_bank.sv
// Peripheral interrupt enable-two and request-one registers with core request gating.
//
// Functional notes
// - Enable-two bits six to zero; bit seven zero.
// - Enable-two bits writable, reset to zero.
// - Peripheral gate must be set for requests; the code gates only core_irq_request, irq ignores the gate.
// - Request-one bit layout, one means pending.
//
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module pief_bank (
   // Clock and reset.
   input wire logic clk,
   input wire logic resetn,
   // Avalon-MM slave.
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Peripheral event lines for request-one, from outside this clock domain.
   input wire logic [7:0] request_one_src,
   // Flags of the enable-two sources, held elsewhere on this clock.
   input wire logic [6:0] enable_two_src_flags,
   // Enable-one register value, held elsewhere on this clock.
   input wire logic [7:0] enable_one,
   // Requests.
   output logic core_irq_request,
   output logic irq
);
   // ----------------------------------------------------------------
   // State.
   // ----------------------------------------------------------------
   logic [7:0] enable_two_q; // Enable-two register.
   logic [7:0] request_one_q; // Pending flags of request-one.
   logic [7:0] core_ctrl_q; // Global and peripheral gates.
   logic [7:0] status_q; // Sticky flag-set events.
   logic [7:0] mask_q; // Interrupt mask over status.
   logic [7:0] rd_snap_q; // Status value handed out by the pending read.
   logic [31:0] readdata_q;
   logic wait_q;
   logic core_req_q;
   logic irq_q;
   logic [7:0] src_level;
   logic [7:0] src_rise;
   logic req;
   logic acc_wr;
   logic acc_rd;
   logic [7:0] rd_word;
   logic gates_on;
   logic any_pending;

   // ----------------------------------------------------------------
   // Source synchronisation.
   // ----------------------------------------------------------------
   pief_evsync u_sync (
      .clk(clk),
      .resetn(resetn),
      .src_async(request_one_src),
      .level_q(src_level),
      .rise_q(src_rise)
   );

   // ----------------------------------------------------------------
   // Bus handshake.
   // ----------------------------------------------------------------
   assign req = read | write;
   // A request is taken in the cycle in which waitrequest is low.
   assign acc_wr = write & ~wait_q;
   assign acc_rd = read & ~wait_q;

   // Waitrequest drops for one cycle, the cycle after a request is seen.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wait_q <= 1'b1;
      end else if (req && wait_q) begin
         wait_q <= 1'b0;
      end else begin
         wait_q <= 1'b1;
      end
   end

   // Read mux; unmapped addresses read as zero.
   always_comb begin
      case (address)
         pief_pkg::OFS_ENABLE_TWO: rd_word = enable_two_q & pief_pkg::ENABLE_TWO_MASK;
         pief_pkg::OFS_REQUEST_ONE: rd_word = request_one_q;
         pief_pkg::OFS_CORE_CTRL: rd_word = core_ctrl_q;
         pief_pkg::OFS_IRQ_STATUS: rd_word = status_q;
         pief_pkg::OFS_IRQ_MASK: rd_word = mask_q;
         default: rd_word = 8'h00;
      endcase
   end

   // Read data is captured while waitrequest is high so it stands at the taking edge.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         readdata_q <= 32'h0000_0000;
         rd_snap_q <= 8'h00;
      end else if (read && wait_q) begin
         readdata_q <= {24'h00_0000, rd_word};
         rd_snap_q <= (address == pief_pkg::OFS_IRQ_STATUS) ? status_q : 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Enable-two register.
   // ----------------------------------------------------------------
   // bit seven never stored, all reset to zero
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         enable_two_q <= pief_pkg::ENABLE_TWO_RST;
      end else if (acc_wr && address == pief_pkg::OFS_ENABLE_TWO) begin
         enable_two_q <= writedata[7:0] & pief_pkg::ENABLE_TWO_MASK;
      end
   end

   // ----------------------------------------------------------------
   // Request-one flags.
   // ----------------------------------------------------------------
   // events set flags, set wins over a clearing write
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         request_one_q <= pief_pkg::REQUEST_ONE_RST;
      end else begin
         if (acc_wr && address == pief_pkg::OFS_REQUEST_ONE) begin
            request_one_q <= ((writedata[7:0] & pief_pkg::REQUEST_ONE_RW_MASK) | src_rise)
                             & pief_pkg::REQUEST_ONE_RW_MASK
                             | (src_level & ~pief_pkg::REQUEST_ONE_RW_MASK);
         end else begin
            // Read-only bits mirror their source; the rest are sticky.
            request_one_q <= ((request_one_q | src_rise) & pief_pkg::REQUEST_ONE_RW_MASK)
                             | (src_level & ~pief_pkg::REQUEST_ONE_RW_MASK);
         end
      end
   end

   // ----------------------------------------------------------------
   // Core control, mask and status.
   // ----------------------------------------------------------------
   // Gate bits live here since no other register in this block holds them.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         core_ctrl_q <= pief_pkg::CORE_CTRL_RST;
         mask_q <= pief_pkg::IRQ_MASK_RST;
      end else if (acc_wr) begin
         if (address == pief_pkg::OFS_CORE_CTRL) begin
            core_ctrl_q <= writedata[7:0];
         end
         if (address == pief_pkg::OFS_IRQ_MASK) begin
            mask_q <= writedata[7:0];
         end
      end
   end

   // A read clears only the bits it returned; a new event in that cycle survives.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         status_q <= pief_pkg::IRQ_STATUS_RST;
      end else if (acc_rd && address == pief_pkg::OFS_IRQ_STATUS) begin
         status_q <= (status_q & ~rd_snap_q) | src_rise;
      end else begin
         status_q <= status_q | src_rise;
      end
   end

   // ----------------------------------------------------------------
   // Request outputs.
   // ----------------------------------------------------------------
   assign gates_on = core_ctrl_q[pief_pkg::GLOBAL_IRQ_GATE_BIT]
                     & core_ctrl_q[pief_pkg::PERIPHERAL_IRQ_GATE_BIT];
   assign any_pending = (|(request_one_q & enable_one))
                        | (|(enable_two_src_flags & enable_two_q[6:0]));

   // gated OR of flag and enable for the core request; irq is the ungated OR of status and mask
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         core_req_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         core_req_q <= gates_on & any_pending;
         irq_q <= |(status_q & mask_q);
      end
   end

   assign readdata = readdata_q;
   assign waitrequest = wait_q;
   assign core_irq_request = core_req_q;
   assign irq = irq_q;

   // ----------------------------------------------------------------
   // Checks.
   // ----------------------------------------------------------------
   sequence s_en2_write;
      acc_wr && address == pief_pkg::OFS_ENABLE_TWO;
   endsequence

   chk_en2_top_zero: assert property (@(posedge clk) disable iff (!resetn)
      acc_rd && address == pief_pkg::OFS_ENABLE_TWO |-> readdata_q[31:7] == 25'h0)
      else $error("Enable-two read shows a set bit seven.");

   chk_en2_write_takes: assert property (@(posedge clk) disable iff (!resetn)
      s_en2_write |=> enable_two_q[6:0] == $past(writedata[6:0]))
      else $error("Enable-two write not stored.");

   chk_gate_blocks_req: assert property (@(posedge clk) disable iff (!resetn)
      !core_ctrl_q[pief_pkg::PERIPHERAL_IRQ_GATE_BIT] |=> !core_irq_request)
      else $error("Core request raised with peripheral gate clear.");

   chk_flag_event_set: assert property (@(posedge clk) disable iff (!resetn)
      |(src_rise & pief_pkg::REQUEST_ONE_RW_MASK) |=>
      (request_one_q & $past(src_rise & pief_pkg::REQUEST_ONE_RW_MASK))
      == $past(src_rise & pief_pkg::REQUEST_ONE_RW_MASK))
      else $error("Event did not set its flag.");

   chk_ro_bits_follow: assert property (@(posedge clk) disable iff (!resetn)
      1'b1 |=> request_one_q[5:4] == $past(src_level[5:4]))
      else $error("Read-only flags do not follow their source.");

   chk_core_req_or: assert property (@(posedge clk) disable iff (!resetn)
      gates_on && (|(request_one_q & enable_one)) |=> core_irq_request)
      else $error("Enabled pending flag did not raise core request.");
endmodule : pief_bank

// File: dv/pief_src_model.sv
// Model of the event sources and the neighbouring enable and flag holders.
`timescale 1ns/10ps
module pief_src_model (
   // Clock.
   input wire logic clk,
   // Commands from the test sequence.
   input wire logic [7:0] src_cmd,
   input wire logic [6:0] flags_cmd,
   input wire logic [7:0] en_cmd,
   // Event lines and neighbour state.
   output logic [7:0] request_one_src,
   output logic [6:0] enable_two_src_flags,
   output logic [7:0] enable_one
);
   // ----------------------------------------------------------------
   // Source and neighbour registers.
   // ----------------------------------------------------------------
   // event condition
   // Each line follows its command one edge later, as a real source register would.
   always_ff @(posedge clk) begin
      request_one_src <= src_cmd;
      enable_two_src_flags <= flags_cmd;
      enable_one <= en_cmd;
   end
endmodule : pief_src_model

// File: dv/testbench.sv
// Self-checking bench for the interrupt enable and flag bank.
`timescale 1ns/10ps
module testbench;
   // ----------------------------------------------------------------
   // Signals.
   // ----------------------------------------------------------------
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [4:0] address = 5'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic waitrequest;
   logic [7:0] request_one_src;
   logic [6:0] enable_two_src_flags;
   logic [7:0] enable_one;
   // Commands to the partner model; all quiet at start.
   logic [7:0] src_cmd = 8'h00;
   logic [6:0] flags_cmd = 7'h00;
   logic [7:0] en_cmd = 8'h00;
   logic core_irq_request;
   logic irq;
   int errors = 0;
   int n_compared = 0;
   // Last read value taken at the accepting edge.
   logic [31:0] rd;

   // Clock at 20 MHz.
   always #25 clk = ~clk;

   pief_bank pief_bank_inst (.clk(clk), .resetn(resetn), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .request_one_src(request_one_src), .enable_two_src_flags(enable_two_src_flags),
      .enable_one(enable_one), .core_irq_request(core_irq_request), .irq(irq));

   pief_src_model pief_src_model_inst (.clk(clk), .src_cmd(src_cmd), .flags_cmd(flags_cmd),
      .en_cmd(en_cmd), .request_one_src(request_one_src),
      .enable_two_src_flags(enable_two_src_flags), .enable_one(enable_one));

   // ----------------------------------------------------------------
   // Helpers.
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : final_report

   // One Avalon transfer; the request stands until waitrequest is seen low.
   task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
      int i;
      @(posedge clk);
      address <= a;
      write <= wr;
      read <= ~wr;
      writedata <= {24'h0, d};
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (waitrequest === 1'b0) break;
      end
      rd = readdata;
      write <= 1'b0;
      read <= 1'b0;
      // A slave that never answers ends the run rather than hanging it.
      if (i == 20) begin
         errors++;
         final_report();
      end
   endtask : bus

   // Event lines are held eight cycles, long enough for the synchroniser to pass them.
   task automatic set_src(input logic [7:0] v);
      @(posedge clk);
      src_cmd <= v;
      repeat (8) @(posedge clk);
   endtask : set_src

   // Pending flags of the enable-two sources, changed on a clock edge.
   task automatic set_flags(input logic [6:0] v);
      @(posedge clk);
      flags_cmd <= v;
   endtask : set_flags

   // Enable-one value held by a neighbouring register.
   task automatic set_en(input logic [7:0] v);
      @(posedge clk);
      en_cmd <= v;
   endtask : set_en

   task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      check(rd, {24'h0, exp});
   endtask : rchk

   // Request outputs lag by a cycle, so sample a few edges later at mid-cycle.
   task automatic lvl(input bit use_irq, input logic exp);
      repeat (4) @(posedge clk);
      @(negedge clk);
      check({31'h0, use_irq ? irq : core_irq_request}, {31'h0, exp});
   endtask : lvl

   // ----------------------------------------------------------------
   // Main sequence.
   // ----------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      for (int k = 0; k < 5; k++) rchk(5'(k * 4), 8'h00);
      $display("test reset values done");
      bus(1'b1, 5'h00, 8'hff);
      rchk(5'h00, 8'h7f);
      bus(1'b1, 5'h14, 8'hff);
      rchk(5'h14, 8'h00);
      bus(1'b1, 5'h04, 8'hff);
      rchk(5'h04, 8'hcf);
      bus(1'b1, 5'h04, 8'h00);
      rchk(5'h04, 8'h00);
      $display("test register access done");
      set_src(8'hff);
      rchk(5'h04, 8'hff);
      lvl(1'b0, 1'b0);
      set_src(8'h00);
      rchk(5'h04, 8'hcf);
      $display("test event flags done");
      set_en(8'h01);
      bus(1'b1, 5'h08, 8'h80);
      lvl(1'b0, 1'b0);
      bus(1'b1, 5'h08, 8'h40);
      lvl(1'b0, 1'b0);
      bus(1'b1, 5'h08, 8'hc0);
      lvl(1'b0, 1'b1);
      // stale flags cleared before a new enable
      bus(1'b1, 5'h04, 8'h00);
      lvl(1'b0, 1'b0);
      bus(1'b1, 5'h00, 8'h40);
      set_flags(7'h3f);
      lvl(1'b0, 1'b0);
      set_flags(7'h40);
      lvl(1'b0, 1'b1);
      set_flags(7'h00);
      $display("test request gating done");
      rchk(5'h0c, 8'hff);
      rchk(5'h0c, 8'h00);
      set_src(8'h01);
      lvl(1'b1, 1'b0);
      bus(1'b1, 5'h10, 8'h01);
      lvl(1'b1, 1'b1);
      rchk(5'h0c, 8'h01);
      lvl(1'b1, 1'b0);
      $display("test status and mask done");
      final_report();
   end
endmodule : testbench
